// File: hdl/motion_led_burst_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module motion_led_burst_config_regs #(
    parameter logic [7:0] REVISION     = 8'h5a, // Arbitrary value
    parameter int         PULSE_LENGTH = motion_regs_pkg::PULSE_CYCLES
) (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_chip_select_n,
    input  wire logic       i_sclk,
    input  wire logic       i_mosi,
    input  wire logic       i_motion_event,
    input  wire logic [7:0] i_delta_x,
    input  wire logic [7:0] i_delta_y,
    output logic            o_miso,
    output logic            o_miso_oe,
    output logic            o_motion,
    output logic            o_led_on,
    output logic [1:0]      o_led_current,
    output logic            o_auto_current
);
    // ====================================================================
    // Pin synchronisation
    logic [2:0] pins;
    pin_sync #(.WIDTH(3)) u_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async ({i_chip_select_n, i_sclk, i_mosi}),
        .o_sync  (pins)
    );
    logic cs_n, sclk, mosi, sclk_d;
    assign cs_n = pins[2];
    assign sclk = pins[1];
    assign mosi = pins[0];

    // ====================================================================
    // SCLK edges
    // Each SCLK phase must last over one clock or an edge is lost
    logic rise, fall;
    assign rise = sclk & ~sclk_d;
    assign fall = ~sclk & sclk_d;

    // ====================================================================
    // Registers
    logic [7:0] led_drive_control, next_led_drive_control;
    logic [7:0] motion_output_config, next_motion_output_config;
    logic [7:0] burst_start_address, next_burst_start_address;
    logic [7:0] auto_led, next_auto_led;
    logic [7:0] dx, next_dx;
    logic [7:0] dy, next_dy;
    logic       pending, next_pending;
    logic       x_read, next_x_read;

    // ====================================================================
    // Serial port
    motion_regs_pkg::spi_state_e state, next_state;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [7:0] shreg, next_shreg;
    logic [6:0] addr, next_addr;
    logic       wr, next_wr;
    logic       burst, next_burst;
    logic [7:0] txreg, next_txreg;
    logic       miso, next_miso;
    logic       miso_oe, next_miso_oe;

    // ====================================================================
    // Read decode
    // Read data is latched on the eighth rise so the first fall drives bit 7
    function automatic logic [7:0] read_reg(input logic [6:0] a);
        unique case (a)
            motion_regs_pkg::REV_ID_ADDR:        read_reg = REVISION;
            motion_regs_pkg::INV_REV_ADDR:       read_reg = ~REVISION;
            motion_regs_pkg::MOTION_STATUS_ADDR: read_reg = {pending, 7'h00};
            motion_regs_pkg::DELTA_X_ADDR:       read_reg = dx;
            motion_regs_pkg::DELTA_Y_ADDR:       read_reg = dy;
            motion_regs_pkg::LED_DRIVE_ADDR:     read_reg = led_drive_control;
            motion_regs_pkg::MOTION_CFG_ADDR:    read_reg = motion_output_config;
            motion_regs_pkg::BURST_START_ADDR:   read_reg = burst_start_address;
            motion_regs_pkg::AUTO_LED_ADDR:      read_reg = auto_led;
            default:                             read_reg = 8'h00;
        endcase
    endfunction

    logic       rd_strobe;
    logic [6:0] rd_addr;

    always_comb begin
        next_state   = state;
        next_bit_cnt = bit_cnt;
        next_shreg   = shreg;
        next_addr    = addr;
        next_wr      = wr;
        next_burst   = burst;
        next_txreg   = txreg;
        next_miso    = miso;
        next_miso_oe = miso_oe;
        next_led_drive_control    = led_drive_control;
        next_motion_output_config = motion_output_config;
        next_burst_start_address  = burst_start_address;
        next_auto_led             = auto_led;
        rd_strobe = 1'b0;
        rd_addr   = addr;
        if (cs_n) begin
            // Deselect ends any burst; start address survives for reuse
            next_state   = motion_regs_pkg::SP_IDLE;
            next_bit_cnt = 3'h0;
            next_miso_oe = 1'b0;
            next_burst   = 1'b0;
        end else begin
            next_miso_oe = 1'b1;
            if (fall) begin
                next_miso  = txreg[7];
                next_txreg = {txreg[6:0], 1'b0};
            end
            if (rise) begin
                next_shreg   = {shreg[6:0], mosi};
                next_bit_cnt = bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    unique case (state)
                        motion_regs_pkg::SP_IDLE,
                        motion_regs_pkg::SP_ADDR: begin
                            next_wr   = shreg[6];
                            next_addr = {shreg[5:0], mosi};
                            next_state = motion_regs_pkg::SP_DATA;
                            if (!shreg[6]) begin
                                if ({shreg[5:0], mosi} == motion_regs_pkg::BURST_ADDR) begin
                                    next_burst = 1'b1;
                                    rd_addr    = burst_start_address[6:0];
                                    next_addr  = burst_start_address[6:0];
                                end else begin
                                    rd_addr = {shreg[5:0], mosi};
                                end
                                rd_strobe  = 1'b1;
                                next_txreg = read_reg(rd_addr);
                            end
                        end
                        motion_regs_pkg::SP_DATA: begin
                            if (wr) begin
                                next_state = motion_regs_pkg::SP_ADDR;
                                unique case (addr)
                                    motion_regs_pkg::LED_DRIVE_ADDR:
                                        next_led_drive_control =
                                            {shreg[6:0], mosi} & motion_regs_pkg::LED_DRIVE_MASK;
                                    motion_regs_pkg::MOTION_CFG_ADDR:
                                        next_motion_output_config =
                                            {shreg[6:0], mosi} & motion_regs_pkg::MOTION_CFG_MASK;
                                    motion_regs_pkg::BURST_START_ADDR:
                                        next_burst_start_address = {shreg[6:0], mosi};
                                    motion_regs_pkg::AUTO_LED_ADDR:
                                        next_auto_led = {shreg[6:0], mosi} & motion_regs_pkg::AUTO_LED_MASK;
                                    default: ;
                                endcase
                            end else if (burst) begin
                                // Burst steps up to delta Y then keeps reading it; a start above delta Y keeps reading the start register
                                if (addr < motion_regs_pkg::DELTA_Y_ADDR) begin
                                    next_addr = addr + 7'h01;
                                end
                                rd_addr    = (addr < motion_regs_pkg::DELTA_Y_ADDR) ? addr + 7'h01 : addr;
                                rd_strobe  = 1'b1;
                                next_txreg = read_reg(rd_addr);
                            end else begin
                                next_state = motion_regs_pkg::SP_ADDR;
                            end
                        end
                        default: next_state = motion_regs_pkg::SP_IDLE;
                    endcase
                end
            end
        end
    end

    // ====================================================================
    // Motion data and output
    logic [17:0] pulse_cnt, next_pulse_cnt;
    logic        motion, next_motion;
    logic        edge_mode, active_high;
    assign edge_mode   = motion_output_config[motion_regs_pkg::EDGE_SEL_BIT];
    assign active_high = motion_output_config[motion_regs_pkg::POLARITY_BIT];

    always_comb begin
        next_dx        = dx;
        next_dy        = dy;
        next_pending   = pending;
        next_x_read    = x_read;
        next_pulse_cnt = pulse_cnt;
        // Reading Y after X completes the read-out
        if (rd_strobe && rd_addr == motion_regs_pkg::DELTA_X_ADDR) begin
            next_x_read = 1'b1;
        end
        if (rd_strobe && rd_addr == motion_regs_pkg::DELTA_Y_ADDR && x_read) begin
            next_dx      = 8'h00;
            next_dy      = 8'h00;
            next_pending = 1'b0;
            next_x_read  = 1'b0;
        end
        // New motion wins over a clear in the same cycle
        // Pulse restarts on each event, so close events stretch it
        if (i_motion_event) begin
            next_dx      = i_delta_x;
            next_dy      = i_delta_y;
            next_pending = 1'b1;
            next_x_read  = 1'b0;
            next_pulse_cnt = 18'(PULSE_LENGTH);
        end else if (pulse_cnt != 18'h0) begin
            next_pulse_cnt = pulse_cnt - 18'h1;
        end
        if (edge_mode) begin
            next_motion = (pulse_cnt != 18'h0) ? active_high : ~active_high;
        end else begin
            next_motion = pending ? active_high : ~active_high;
        end
    end

    // ====================================================================
    // LED drive
    logic       next_led_on, next_auto;
    logic [1:0] next_current;

    always_comb begin
        next_led_on  = ~led_drive_control[motion_regs_pkg::LAMP_OFF_BIT];
        next_auto    = ~auto_led[motion_regs_pkg::AUTO_DIS_BIT];
        // Auto mode shows the 30 mA code; fixed field only when auto is off
        next_current = next_auto ? motion_regs_pkg::CUR_30MA
                                 : led_drive_control[motion_regs_pkg::CUR_SEL_LSB +: 2];
    end

    // ====================================================================
    // State registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state   <= motion_regs_pkg::SP_IDLE;
            bit_cnt <= 3'h0;
            shreg   <= 8'h00;
            addr    <= 7'h00;
            wr      <= 1'b0;
            burst   <= 1'b0;
            txreg   <= 8'h00;
            miso    <= 1'b0;
            miso_oe <= 1'b0;
            sclk_d  <= 1'b1;
            led_drive_control    <= motion_regs_pkg::LED_DRIVE_RESET;
            motion_output_config <= motion_regs_pkg::MOTION_CFG_RESET;
            burst_start_address  <= motion_regs_pkg::BURST_START_RESET;
            auto_led             <= motion_regs_pkg::AUTO_LED_RESET;
            dx        <= 8'h00;
            dy        <= 8'h00;
            pending   <= 1'b0;
            x_read    <= 1'b0;
            pulse_cnt <= 18'h0;
            motion    <= 1'b1;
            o_led_on       <= 1'b1;
            o_led_current  <= motion_regs_pkg::CUR_30MA;
            o_auto_current <= 1'b1;
        end else begin
            state   <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg   <= next_shreg;
            addr    <= next_addr;
            wr      <= next_wr;
            burst   <= next_burst;
            txreg   <= next_txreg;
            miso    <= next_miso;
            miso_oe <= next_miso_oe;
            sclk_d  <= sclk;
            led_drive_control    <= next_led_drive_control;
            motion_output_config <= next_motion_output_config;
            burst_start_address  <= next_burst_start_address;
            auto_led             <= next_auto_led;
            dx        <= next_dx;
            dy        <= next_dy;
            pending   <= next_pending;
            x_read    <= next_x_read;
            pulse_cnt <= next_pulse_cnt;
            motion    <= next_motion;
            o_led_on       <= next_led_on;
            o_led_current  <= next_current;
            o_auto_current <= next_auto;
        end
    end

    // ====================================================================
    // Outputs
    assign o_miso    = miso;
    assign o_miso_oe = miso_oe;
    assign o_motion  = motion;
endmodule
`default_nettype wire

// File: hdl/motion_regs_pkg.sv
`default_nettype none
package motion_regs_pkg;
    // ====================================================================
    // Register map
    localparam logic [6:0] REV_ID_ADDR        = 7'h01;
    localparam logic [6:0] MOTION_STATUS_ADDR = 7'h02;
    localparam logic [6:0] DELTA_X_ADDR       = 7'h03;
    localparam logic [6:0] DELTA_Y_ADDR       = 7'h04;
    localparam logic [6:0] INV_REV_ADDR       = 7'h3f;
    localparam logic [6:0] LED_DRIVE_ADDR     = 7'h40;
    localparam logic [6:0] MOTION_CFG_ADDR    = 7'h41;
    localparam logic [6:0] BURST_START_ADDR   = 7'h42;
    localparam logic [6:0] AUTO_LED_ADDR      = 7'h43;
    localparam logic [6:0] BURST_ADDR         = 7'h63;
    // ====================================================================
    // Field positions
    localparam int LAMP_OFF_BIT    = 3;
    localparam int CUR_SEL_LSB     = 0;
    localparam int AUTO_DIS_BIT    = 0;
    localparam int EDGE_SEL_BIT    = 6;
    localparam int POLARITY_BIT    = 7;
    localparam int STATUS_MOT_BIT  = 7;
    // ====================================================================
    // Reset values and masks
    localparam logic [7:0] LED_DRIVE_RESET   = 8'h00;
    localparam logic [7:0] LED_DRIVE_MASK    = 8'h0b;
    localparam logic [7:0] MOTION_CFG_RESET  = 8'h40;
    localparam logic [7:0] MOTION_CFG_MASK   = 8'hc0;
    localparam logic [7:0] BURST_START_RESET = 8'h03;
    localparam logic [7:0] AUTO_LED_RESET    = 8'h08;
    localparam logic [7:0] AUTO_LED_MASK     = 8'h0f;
    // ====================================================================
    // Current codes
    localparam logic [1:0] CUR_20MA = 2'h0;
    localparam logic [1:0] CUR_15MA = 2'h1;
    localparam logic [1:0] CUR_36MA = 2'h2;
    localparam logic [1:0] CUR_30MA = 2'h3;
    // ====================================================================
    // Timing
    localparam int CLK_PERIOD_NS   = 8;
    localparam int PULSE_TIME_US   = 230;
    localparam int PULSE_CYCLES    = (PULSE_TIME_US * 1000) / CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        SP_IDLE = 3'b001,
        SP_ADDR = 3'b010,
        SP_DATA = 3'b100
    } spi_state_e;
endpackage
`default_nettype wire

// File: hdl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            stage1 <= '1;
            o_sync <= '1;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule
`default_nettype wire

// File: verif/motion_led_burst_config_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module motion_led_burst_config_regs_test;
    localparam int         PULSE = 20;
    localparam logic [7:0] REV   = 8'h5a; // Arbitrary value
    logic        i_clk, i_reset, i_motion_event, cs_n, sclk, mosi;
    logic        o_miso, o_miso_oe, o_motion, o_led_on, o_auto_current, miso_line;
    logic [1:0]  o_led_current;
    logic [7:0]  i_delta_x, i_delta_y, v, d, dx, dy;
    logic [31:0] seed = 32'h3e5944b8;
    int          error_cnt = 0;
    int          tests_run = 0;
    motion_led_burst_config_regs #(.REVISION(REV), .PULSE_LENGTH(PULSE)) dut (.i_clk(i_clk), .i_reset(i_reset),
        .i_chip_select_n(cs_n), .i_sclk(sclk), .i_mosi(mosi), .i_motion_event(i_motion_event),
        .i_delta_x(i_delta_x), .i_delta_y(i_delta_y), .o_miso(o_miso), .o_miso_oe(o_miso_oe), .o_motion(o_motion),
        .o_led_on(o_led_on), .o_led_current(o_led_current), .o_auto_current(o_auto_current));
    // Released data line shows the inverse so a stray sample is caught
    assign miso_line = o_miso_oe ? o_miso : ~o_miso;
    serial_host_model host (.i_clk(i_clk), .i_miso(miso_line), .o_chip_select_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));
    initial i_clk = 1'b0;
    always #4 i_clk = ~i_clk;
    // ====================================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [1:0] want_cur(input logic [7:0] led, input logic [7:0] auto_reg);
        return auto_reg[0] ? led[1:0] : 2'h3;
    endfunction
    task automatic complete_run();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] dat);
        logic [7:0] r;
        host.select(1'b1);
        host.xfer({1'b1, a}, r);
        host.xfer(dat, r);
        host.select(1'b0);
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] dat);
        logic [7:0] r;
        host.select(1'b1);
        host.xfer({1'b0, a}, r);
        host.xfer(8'ha5, dat);
        host.select(1'b0);
    endtask
    task automatic wait_motion(input logic lvl);
        int k = 0;
        while (o_motion !== lvl && k < 8) begin
            @(posedge i_clk);
            #1;
            k++;
        end
        chk("motion level", {7'h0, lvl}, {7'h0, o_motion});
        if (o_motion !== lvl) complete_run();
    endtask
    task automatic motion();
        dx = 8'(rnd());
        dy = 8'(rnd());
        i_delta_x = dx;
        i_delta_y = dy;
        i_motion_event = 1'b1;
        @(posedge i_clk);
        #1;
        i_motion_event = 1'b0;
    endtask
    task automatic pulse(input logic act);
        int k = 0;
        wait_motion(act);
        while (o_motion === act && k < 100) begin
            @(posedge i_clk);
            #1;
            k++;
        end
        chk("pulse width", 8'(PULSE), 8'(k));
    endtask
    task automatic read_out();
        rd(7'h02, v);
        chk("status pending", 8'h80, v & 8'h80);
        rd(7'h03, v);
        chk("delta x", dx, v);
        rd(7'h04, v);
        chk("delta y", dy, v);
    endtask
    task automatic check_reset();
        logic [6:0] ra [6];
        logic [7:0] re [6];
        ra = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h3f, 7'h01};
        re = '{8'h00, 8'h40, 8'h03, 8'h08, ~REV, REV};
        i_reset = 1'b1;
        repeat (3) @(posedge i_clk);
        #1;
        i_reset = 1'b0;
        chk("lamp on", 8'h01, {7'h0, o_led_on});
        chk("auto on", 8'h01, {7'h0, o_auto_current});
        chk("current reset", 8'h03, {6'h0, o_led_current});
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], v);
            chk("reset value", re[i], v);
        end
    endtask
    // ====================================================================
    // Main sequence
    initial begin
        i_motion_event = 1'b0;
        i_delta_x = 8'h00;
        i_delta_y = 8'h00;
        check_reset();
        wr(7'h3f, 8'h00);
        wr(7'h7e, 8'hff);
        rd(7'h3f, v);
        chk("inverted revision", ~REV, v);
        wr(7'h43, 8'h01);
        chk("auto off", 8'h00, {7'h0, o_auto_current});
        for (int c = 3; c >= 0; c--) begin
            d = (8'(rnd()) & 8'hf4) | {4'h0, 1'(c), 1'b0, 2'(c)};
            wr(7'h40, d);
            rd(7'h40, v);
            chk("lamp control", d & 8'h0b, v);
            chk("lamp on", {7'h0, !d[3]}, {7'h0, o_led_on});
            chk("current", {6'h0, want_cur(d, 8'h01)}, {6'h0, o_led_current});
        end
        wr(7'h43, 8'h08);
        chk("current auto", {6'h0, want_cur(d, 8'h08)}, {6'h0, o_led_current});
        motion();
        pulse(1'b0);
        read_out();
        wr(7'h41, 8'hff);
        rd(7'h41, v);
        chk("motion config", 8'hc0, v);
        wait_motion(1'b0);
        motion();
        pulse(1'b1);
        read_out();
        wr(7'h41, 8'h00);
        wait_motion(1'b1);
        motion();
        wait_motion(1'b0);
        repeat (2 * PULSE) @(posedge i_clk);
        #1;
        chk("level held", 8'h00, {7'h0, o_motion});
        read_out();
        wait_motion(1'b1);
        rd(7'h03, v);
        chk("x cleared", 8'h00, v);
        rd(7'h04, v);
        chk("y cleared", 8'h00, v);
        wr(7'h41, 8'h80);
        wait_motion(1'b0);
        motion();
        wait_motion(1'b1);
        host.select(1'b1);
        host.xfer(8'h63, v);
        host.xfer(8'h00, v);
        chk("burst x", dx, v);
        host.xfer(8'h00, v);
        chk("burst y", dy, v);
        host.select(1'b0);
        wait_motion(1'b0);
        motion();
        host.select(1'b1);
        host.xfer(8'hc2, v);
        host.xfer(8'h02, v);
        host.xfer(8'h63, v);
        host.xfer(8'h00, v);
        chk("burst status", 8'h80, v & 8'h80);
        host.xfer(8'h00, v);
        chk("burst x", dx, v);
        host.xfer(8'h00, v);
        chk("burst y", dy, v);
        host.select(1'b0);
        rd(7'h42, v);
        chk("burst start", 8'h02, v);
        wr(7'h40, 8'h09);
        wr(7'h43, 8'h01);
        chk("current fixed", 8'h01, {6'h0, o_led_current});
        check_reset();
        motion();
        pulse(1'b0);
        complete_run();
    end
    initial begin
        repeat (100000) @(posedge i_clk);
        error_cnt++;
        complete_run();
    end
endmodule
`default_nettype wire

// File: verif/motion_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module motion_regs_chk #(
    parameter int PULSE_LENGTH = 20
) (
    input wire logic       i_clk,
    input wire logic       i_reset,
    input wire logic       i_chip_select_n,
    input wire logic       i_sclk,
    input wire logic       i_mosi,
    input wire logic       i_motion_event,
    input wire logic [7:0] i_delta_x,
    input wire logic [7:0] i_delta_y,
    input wire logic       o_miso,
    input wire logic       o_miso_oe,
    input wire logic       o_motion,
    input wire logic       o_led_on,
    input wire logic [1:0] o_led_current,
    input wire logic       o_auto_current
);
    // ====================================================================
    // Ages of the causes that may move the motion pin
    int   ev_age, cs_age, run, next_ev_age, next_cs_age, next_run;
    logic prev_motion;
    always_comb begin
        next_ev_age = i_motion_event ? 0 : ((ev_age < 999) ? ev_age + 1 : ev_age);
        next_cs_age = !i_chip_select_n ? 0 : ((cs_age < 999) ? cs_age + 1 : cs_age);
        next_run    = (o_motion != prev_motion) ? 0 : ((run < 99999) ? run + 1 : run);
    end
    always_ff @(posedge i_clk) begin
        ev_age      <= i_reset ? 999 : next_ev_age;
        cs_age      <= i_reset ? 999 : next_cs_age;
        run         <= i_reset ? 0 : next_run;
        prev_motion <= i_reset ? 1'b1 : o_motion;
    end
    // ====================================================================
    // Assertions
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_reset_state: assert property ($past(i_reset) |-> o_motion && o_led_current == 2'h3 && !o_miso_oe)
        else $error("outputs not at reset state");
    a_auto_hold: assert property ($past(i_reset) |-> (o_auto_current && o_led_on) [*8])
        else $error("auto current or lamp lost after reset");
    a_auto_override: assert property (o_auto_current |-> o_led_current == 2'h3)
        else $error("fixed current used while auto enabled");
    a_cfg_cause: assert property ($changed({o_led_on, o_led_current, o_auto_current}) |->
        !i_chip_select_n || !$past(i_chip_select_n, 4)) else $error("lamp setting moved without access");
    a_motion_cause: assert property ((o_motion != prev_motion) |-> ev_age <= 4 || cs_age <= 8 ||
        (run >= PULSE_LENGTH - 3 && run <= PULSE_LENGTH + 2)) else $error("motion pin moved without cause");
    a_oe_on: assert property (!i_chip_select_n [*6] |-> o_miso_oe)
        else $error("data out not enabled while selected");
    a_oe_off: assert property (i_chip_select_n [*6] |-> !o_miso_oe)
        else $error("data out enabled while deselected");
    a_miso_fall: assert property ($changed(o_miso) |->
        i_chip_select_n || !i_sclk || !$past(i_sclk) || !$past(i_sclk, 2)) else $error("data out moved off a fall");
endmodule
bind motion_led_burst_config_regs motion_regs_chk #(.PULSE_LENGTH(PULSE_LENGTH)) chk (.i_clk(i_clk),
    .i_reset(i_reset), .i_chip_select_n(i_chip_select_n), .i_sclk(i_sclk), .i_mosi(i_mosi),
    .i_motion_event(i_motion_event), .i_delta_x(i_delta_x), .i_delta_y(i_delta_y), .o_miso(o_miso),
    .o_miso_oe(o_miso_oe), .o_motion(o_motion), .o_led_on(o_led_on), .o_led_current(o_led_current),
    .o_auto_current(o_auto_current));
`default_nettype wire

// File: verif/serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
    input  wire logic i_clk,
    input  wire logic i_miso,
    output logic      o_chip_select_n,
    output logic      o_sclk,
    output logic      o_mosi
);
    // ====================================================================
    // Four-wire host, serial clock idle high, 64 ns per bit
    initial begin
        o_chip_select_n = 1'b1;
        o_sclk = 1'b1;
        o_mosi = 1'b0;
    end
    task automatic half();
        repeat (4) @(posedge i_clk);
        #1;
    endtask
    task automatic select(input logic on);
        half();
        o_chip_select_n = !on;
        half();
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            o_sclk = 1'b0;
            o_mosi = tx[i];
            half();
            o_sclk = 1'b1;
            half();
            rx[i] = i_miso;
        end
    endtask
endmodule
`default_nettype wire
